//--- verilog/ofcr_defs.vh
// constants for the optical front-end control register bank
// assumes inclusion by bare name from the design file
`ifndef OFCR_DEFS_VH
`define OFCR_DEFS_VH
// -------------------------------------------------------
// apb byte offsets (index times four for pwr through gain only; coff pair and srange sit higher)
// -------------------------------------------------------
`define OFCR_IDX_PWR       4'h0
`define OFCR_IDX_MODE      4'h1
`define OFCR_IDX_FOCUS     4'h2
`define OFCR_IDX_RFOFF     4'h4
`define OFCR_IDX_RFSUMOFF  4'h5
`define OFCR_IDX_GAIN      4'h6
`define OFCR_IDX_COFF_AB   4'h7
`define OFCR_IDX_COFF_CD   4'h8
`define OFCR_IDX_SRANGE    4'h9
`define OFCR_OFF_WORD      12'h000
`define OFCR_OFF_PWR       12'h000
`define OFCR_OFF_MODE      12'h004
`define OFCR_OFF_FOCUS     12'h008
`define OFCR_OFF_RFOFF     12'h010
`define OFCR_OFF_RFSUMOFF  12'h014
`define OFCR_OFF_GAIN      12'h018
`define OFCR_OFF_COFF_AB   12'h030
`define OFCR_OFF_COFF_CD   12'h034
`define OFCR_OFF_SRANGE    12'h040
`define OFCR_OFF_CMD       12'h080
// -------------------------------------------------------
// control word layout
// -------------------------------------------------------
`define OFCR_SEL_HI        15
`define OFCR_SEL_LO        12
`define OFCR_SEL_PWR       4'h0
`define OFCR_SEL_MODE      4'h1
`define OFCR_SEL_FOCUS     4'h2
`define OFCR_SEL_RFOFF     4'h4
`define OFCR_SEL_RFSUMOFF  4'h5
`define OFCR_SEL_GAIN      4'h6
`define OFCR_SEL_COFF_AB   4'hc
`define OFCR_SEL_COFF_CD   4'hd
// used-bit masks per register
`define OFCR_MASK_PWR      12'h0ff
`define OFCR_MASK_MODE     12'h93f
`define OFCR_MASK_FOCUS    12'hfe0
`define OFCR_MASK_RFOFF    12'hfff
`define OFCR_MASK_RF_INPUT_SOURCE_SEL    12'h03f
`define OFCR_MASK_GAIN     12'hfff
`define OFCR_MASK_COFF     12'h0ff
// reset values: standby, lasers off, normal radial polarity
`define OFCR_RST_PWR       12'h000
`define OFCR_RST_MODE      12'h100
`define OFCR_RST_ZERO      12'h000
// field positions
`define OFCR_GAIN_HI       7
`define OFCR_GAIN_LO       5
`define OFCR_GAIN_MAX      3'h4
`define OFCR_B_DVD_LVL     4
`define OFCR_B_CD_LVL      3
`define OFCR_B_DVD_LD      2
`define OFCR_B_CD_LD       1
`define OFCR_B_PWR         0
`define OFCR_B_PSRC        11
`define OFCR_B_RADPOL      8
`define OFCR_B_DOC         5
`define OFCR_B_FOCMODE     4
`define OFCR_RT_HI         3
`define OFCR_RT_LO         1
`define OFCR_B_RFSRC       0
`define OFCR_B_FOFF_EN     10
`define OFCR_LOFF_HI       11
`define OFCR_LOFF_LO       6
`define OFCR_ROFF_HI       5
`define OFCR_ROFF_LO       0
`define OFCR_RG_HI         11
`define OFCR_RG_LO         8
`define OFCR_CG_HI         7
`define OFCR_CG_LO         4
`define OFCR_NIB_HI_HI     7
`define OFCR_NIB_HI_LO     4
`define OFCR_NIB_LO_HI     3
`define OFCR_NIB_LO_LO     0
// radial tracking method codes
`define OFCR_RT_PHASE_AD   3'h0
`define OFCR_RT_PP_AD      3'h1
`define OFCR_RT_PHASE_SUM  3'h4
`define OFCR_RT_PP_FOUR    3'h5
`define OFCR_RT_PHASE_FOUR 3'h6
`endif

//--- verilog/ofcr_regs.v
// optical front-end control register bank behind an apb slave
// assumes a synchronous apb master on pclk; analog settings are plain outputs
`include "ofcr_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ofcr_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  output reg  [2:0]  summed_input_gain,
  output reg         dvd_monitor_level,
  output reg         cd_monitor_level,
  output reg         dvd_laser_enable,
  output reg         cd_laser_enable,
  output reg         power_up_bit,
  output reg         phase_offset_source_sel,
  output reg         radial_polarity,
  output reg         dropout_conceal_enable,
  output reg         focus_four_channel,
  output reg  [2:0]  radial_tracking_method,
  output reg         rf_input_source_sel,
  output reg  [5:0]  phase_offset_value,
  output reg  [5:0]  summed_offset_value,
  output reg  [3:0]  radial_output_gain,
  output reg  [3:0]  central_output_gain,
  output reg  [3:0]  central_offset_a,
  output reg  [3:0]  central_offset_b,
  output reg  [3:0]  central_offset_c,
  output reg  [3:0]  central_offset_d,
  output reg         focus_offset_dac_enable,
  output reg         servo_offset_range_sel,
  output reg         bad_word
);

  // -------------------------------------------------------
  // register storage
  // -------------------------------------------------------
  reg [11:0] power_laser_control;
  reg [11:0] servo_rf_mode_select;
  reg [11:0] focus_ctl;
  reg [11:0] rf_offset;
  reg [11:0] rf_sum_offset;
  reg [11:0] gain_ctl;
  reg [11:0] coff_ab;
  reg [11:0] coff_cd;
  reg        srange;

  wire       wr_en = psel & penable & pwrite;
  wire       rd_en = psel & penable & ~pwrite;
  wire       word_wr = wr_en & (paddr == `OFCR_OFF_CMD);
  wire [3:0] sel = pwdata[`OFCR_SEL_HI:`OFCR_SEL_LO];
  wire [11:0] body = pwdata[11:0];

  // decode used once, for pslverr: is the address a known register
  function addr_known;
    input [11:0] a;
    begin
      case (a)
        `OFCR_OFF_PWR, `OFCR_OFF_MODE, `OFCR_OFF_FOCUS, `OFCR_OFF_RFOFF,
        `OFCR_OFF_RFSUMOFF, `OFCR_OFF_GAIN, `OFCR_OFF_COFF_AB,
        `OFCR_OFF_COFF_CD, `OFCR_OFF_SRANGE, `OFCR_OFF_CMD: addr_known = 1'b1;
        default: addr_known = 1'b0;
      endcase
    end
  endfunction

  // write target: a direct apb offset, or the serial-style word port
  function hit;
    input [11:0] a;
    input [3:0]  s;
    input [11:0] off;
    input [3:0]  want;
    begin
      hit = (a == off) | ((a == `OFCR_OFF_CMD) & (s == want));
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_known(paddr);

  // -------------------------------------------------------
  // write path
  // -------------------------------------------------------
  // word port: selector decides the target; other registers hold
  wire we_pwr      = wr_en & hit(paddr, sel, `OFCR_OFF_PWR, `OFCR_SEL_PWR);
  wire we_mode     = wr_en & hit(paddr, sel, `OFCR_OFF_MODE, `OFCR_SEL_MODE);
  wire we_focus    = wr_en & hit(paddr, sel, `OFCR_OFF_FOCUS, `OFCR_SEL_FOCUS);
  wire we_rfoff    = wr_en & hit(paddr, sel, `OFCR_OFF_RFOFF, `OFCR_SEL_RFOFF);
  wire we_rfsumoff = wr_en & hit(paddr, sel, `OFCR_OFF_RFSUMOFF, `OFCR_SEL_RFSUMOFF);
  wire we_gain     = wr_en & hit(paddr, sel, `OFCR_OFF_GAIN, `OFCR_SEL_GAIN);
  wire we_coff_ab  = wr_en & hit(paddr, sel, `OFCR_OFF_COFF_AB, `OFCR_SEL_COFF_AB);
  wire we_coff_cd  = wr_en & hit(paddr, sel, `OFCR_OFF_COFF_CD, `OFCR_SEL_COFF_CD);
  wire we_srange   = wr_en & (paddr == `OFCR_OFF_SRANGE);

  // selector codes that name a held register
  function sel_held;
    input [3:0] s;
    begin
      case (s)
        `OFCR_SEL_PWR, `OFCR_SEL_MODE, `OFCR_SEL_FOCUS, `OFCR_SEL_RFOFF,
        `OFCR_SEL_RFSUMOFF, `OFCR_SEL_GAIN, `OFCR_SEL_COFF_AB,
        `OFCR_SEL_COFF_CD: sel_held = 1'b1;
        default: sel_held = 1'b0;
      endcase
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_laser_control <= `OFCR_RST_PWR;
    end else if (we_pwr) begin
      power_laser_control <= body & `OFCR_MASK_PWR;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_rf_mode_select <= `OFCR_RST_MODE;
    end else if (we_mode) begin
      servo_rf_mode_select <= body & `OFCR_MASK_MODE;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      focus_ctl <= `OFCR_RST_ZERO;
    end else if (we_focus) begin
      focus_ctl <= body & `OFCR_MASK_FOCUS;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_offset <= `OFCR_RST_ZERO;
    end else if (we_rfoff) begin
      rf_offset <= body & `OFCR_MASK_RFOFF;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_sum_offset <= `OFCR_RST_ZERO;
    end else if (we_rfsumoff) begin
      rf_sum_offset <= body & `OFCR_MASK_RF_INPUT_SOURCE_SEL;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_ctl <= `OFCR_RST_ZERO;
    end else if (we_gain) begin
      gain_ctl <= body & `OFCR_MASK_GAIN;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coff_ab <= `OFCR_RST_ZERO;
    end else if (we_coff_ab) begin
      coff_ab <= body & `OFCR_MASK_COFF;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coff_cd <= `OFCR_RST_ZERO;
    end else if (we_coff_cd) begin
      coff_cd <= body & `OFCR_MASK_COFF;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srange <= 1'b0;
    end else if (we_srange) begin
      srange <= pwdata[0];
    end
  end

  // sticky flag for a word whose selector names no held register; set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_word <= 1'b0;
    end else if (word_wr && !sel_held(sel)) begin
      bad_word <= 1'b1;
    end else if (we_srange && pwdata[1]) begin
      bad_word <= 1'b0;
    end
  end

  // -------------------------------------------------------
  // settings outputs, registered
  // -------------------------------------------------------
  reg [2:0] next_gain;
  reg [5:0] next_phase_off;

  always @* begin
    // reserved gain codes clamp to the top step, no undefined analog state
    next_gain = power_laser_control[`OFCR_GAIN_HI:`OFCR_GAIN_LO];
    if (next_gain > `OFCR_GAIN_MAX) begin
      next_gain = `OFCR_GAIN_MAX;
    end
    if (servo_rf_mode_select[`OFCR_B_PSRC]) begin
      next_phase_off = rf_sum_offset[`OFCR_ROFF_HI:`OFCR_ROFF_LO];
    end else if (servo_rf_mode_select[`OFCR_B_RFSRC]) begin
      next_phase_off = rf_offset[`OFCR_ROFF_HI:`OFCR_ROFF_LO];
    end else begin
      next_phase_off = rf_offset[`OFCR_LOFF_HI:`OFCR_LOFF_LO];
    end
  end

  // -------------------------------------------------------
  // power and laser outputs
  // -------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summed_input_gain <= 3'h0;
      dvd_monitor_level <= 1'b0;
      cd_monitor_level  <= 1'b0;
      dvd_laser_enable  <= 1'b0;
      cd_laser_enable   <= 1'b0;
      power_up_bit      <= 1'b0;
    end else begin
      summed_input_gain <= next_gain;
      dvd_monitor_level <= power_laser_control[`OFCR_B_DVD_LVL];
      cd_monitor_level  <= power_laser_control[`OFCR_B_CD_LVL];
      // lasers not gated by power: sequencing is left to the host
      dvd_laser_enable  <= power_laser_control[`OFCR_B_DVD_LD];
      cd_laser_enable   <= power_laser_control[`OFCR_B_CD_LD];
      power_up_bit      <= power_laser_control[`OFCR_B_PWR];
    end
  end

  // -------------------------------------------------------
  // servo and rf mode outputs
  // -------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_source_sel <= 1'b0;
      radial_polarity         <= 1'b1;
      dropout_conceal_enable  <= 1'b0;
      focus_four_channel      <= 1'b0;
      radial_tracking_method  <= 3'h0;
      rf_input_source_sel     <= 1'b0;
    end else begin
      phase_offset_source_sel <= servo_rf_mode_select[`OFCR_B_PSRC];
      radial_polarity         <= servo_rf_mode_select[`OFCR_B_RADPOL];
      dropout_conceal_enable  <= servo_rf_mode_select[`OFCR_B_DOC];
      focus_four_channel      <= servo_rf_mode_select[`OFCR_B_FOCMODE];
      radial_tracking_method  <= servo_rf_mode_select[`OFCR_RT_HI:`OFCR_RT_LO];
      rf_input_source_sel     <= servo_rf_mode_select[`OFCR_B_RFSRC];
    end
  end

  // -------------------------------------------------------
  // rf offset converter outputs
  // -------------------------------------------------------
  // both converters move on the same edge, so a shared value never splits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_value  <= 6'h00;
      summed_offset_value <= 6'h00;
    end else begin
      phase_offset_value <= next_phase_off;
      if (servo_rf_mode_select[`OFCR_B_RFSRC] && !servo_rf_mode_select[`OFCR_B_PSRC]) begin
        summed_offset_value <= rf_offset[`OFCR_ROFF_HI:`OFCR_ROFF_LO];
      end else begin
        summed_offset_value <= rf_sum_offset[`OFCR_ROFF_HI:`OFCR_ROFF_LO];
      end
    end
  end

  // -------------------------------------------------------
  // servo gain outputs
  // -------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radial_output_gain  <= 4'h0;
      central_output_gain <= 4'h0;
    end else begin
      radial_output_gain  <= gain_ctl[`OFCR_RG_HI:`OFCR_RG_LO];
      central_output_gain <= gain_ctl[`OFCR_CG_HI:`OFCR_CG_LO];
    end
  end

  // -------------------------------------------------------
  // central servo offset outputs
  // -------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      central_offset_a <= 4'h0;
      central_offset_b <= 4'h0;
      central_offset_c <= 4'h0;
      central_offset_d <= 4'h0;
    end else begin
      central_offset_a <= coff_ab[`OFCR_NIB_HI_HI:`OFCR_NIB_HI_LO];
      central_offset_b <= coff_ab[`OFCR_NIB_LO_HI:`OFCR_NIB_LO_LO];
      central_offset_c <= coff_cd[`OFCR_NIB_HI_HI:`OFCR_NIB_HI_LO];
      central_offset_d <= coff_cd[`OFCR_NIB_LO_HI:`OFCR_NIB_LO_LO];
    end
  end

  // -------------------------------------------------------
  // focus converter and offset range outputs
  // -------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      focus_offset_dac_enable <= 1'b0;
      servo_offset_range_sel  <= 1'b0;
    end else begin
      // stored bit is active low: zero means converter on
      focus_offset_dac_enable <= ~focus_ctl[`OFCR_B_FOFF_EN];
      servo_offset_range_sel  <= srange;
    end
  end

  // -------------------------------------------------------
  // read path
  // -------------------------------------------------------
  // selector reads back so software sees the stored word form
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFCR_OFF_PWR:      prdata <= {16'h0000, `OFCR_SEL_PWR, power_laser_control};
        `OFCR_OFF_MODE:     prdata <= {16'h0000, `OFCR_SEL_MODE, servo_rf_mode_select};
        `OFCR_OFF_FOCUS:    prdata <= {16'h0000, `OFCR_SEL_FOCUS, focus_ctl};
        `OFCR_OFF_RFOFF:    prdata <= {16'h0000, `OFCR_SEL_RFOFF, rf_offset};
        `OFCR_OFF_RFSUMOFF: prdata <= {16'h0000, `OFCR_SEL_RFSUMOFF, rf_sum_offset};
        `OFCR_OFF_GAIN:     prdata <= {16'h0000, `OFCR_SEL_GAIN, gain_ctl};
        `OFCR_OFF_COFF_AB:  prdata <= {16'h0000, `OFCR_SEL_COFF_AB, coff_ab};
        `OFCR_OFF_COFF_CD:  prdata <= {16'h0000, `OFCR_SEL_COFF_CD, coff_cd};
        `OFCR_OFF_SRANGE:   prdata <= {30'h0000_0000, bad_word, srange};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  wire unused_rd = rd_en;

endmodule // ofcr_regs

`default_nettype wire

//--- bench/ofcr_regs_sva.sv
// checker: settings outputs follow accepted apb writes
// assumes bind onto ofcr_regs by port name, one clock
`timescale 1ns/1ps
`default_nettype none
module ofcr_regs_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0]  summed_input_gain,
  input wire logic        dvd_laser_enable,
  input wire logic        cd_laser_enable,
  input wire logic        power_up_bit,
  input wire logic        phase_offset_source_sel,
  input wire logic        radial_polarity,
  input wire logic        dropout_conceal_enable,
  input wire logic        focus_four_channel,
  input wire logic [2:0]  radial_tracking_method,
  input wire logic        rf_input_source_sel,
  input wire logic [5:0]  phase_offset_value,
  input wire logic [5:0]  summed_offset_value,
  input wire logic [3:0]  radial_output_gain,
  input wire logic [3:0]  central_output_gain,
  input wire logic        focus_offset_dac_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------------------
  // checked two edges after the write, past the one-edge lag
  // -------------------------------------------------------
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  a_pwr_laser: assert property (s_wr(12'h000) |-> ##2
    {dvd_laser_enable, cd_laser_enable, power_up_bit} == $past(pwdata[2:0], 2))
    else $error("power or laser bit wrong");
  a_gain_code: assert property (s_wr(12'h000) ##0 pwdata[7:5] <= 3'h4 |-> ##2
    summed_input_gain == $past(pwdata[7:5], 2)) else $error("gain code wrong");
  a_mode_bits: assert property (s_wr(12'h004) |-> ##2
    {phase_offset_source_sel, radial_polarity, dropout_conceal_enable,
    focus_four_channel, radial_tracking_method, rf_input_source_sel}
    == $past({pwdata[11], pwdata[8], pwdata[5:0]}, 2)) else $error("mode bits wrong");
  a_word_route: assert property (s_wr(12'h080) ##0 pwdata[15:12] == 4'h1 |-> ##2
    radial_polarity == $past(pwdata[8], 2)) else $error("word not routed");
  a_other_hold: assert property (s_wr(12'h004) |=> $stable(power_up_bit) [*2])
    else $error("power bit moved on mode write");
  a_sum_offset: assert property (s_wr(12'h010) ##0 rf_input_source_sel &&
    !phase_offset_source_sel |-> ##2 phase_offset_value == $past(pwdata[5:0], 2)
    && summed_offset_value == phase_offset_value) else $error("offsets not shared");
  a_servo_gain: assert property (s_wr(12'h018) |-> ##2
    {radial_output_gain, central_output_gain} == $past(pwdata[11:4], 2))
    else $error("servo gains wrong");
  a_focus_dac: assert property (s_wr(12'h008) |-> ##2
    focus_offset_dac_enable == !$past(pwdata[10], 2)) else $error("focus dac wrong");
endmodule // ofcr_regs_sva
bind ofcr_regs ofcr_regs_sva u_sva (.*);
`default_nettype wire

//--- bench/ofcr_apb_host.sv
// apb master model standing in for the decoder
// assumes one clock; waits on pready however long the slave takes
`timescale 1ns/1ps
`default_nettype none
module ofcr_apb_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // idle bus shows inverted data, never a stale copy
    pwdata <= ~d;
  endtask
  task word(input logic [15:0] w);
    logic [31:0] q;
    logic        e;
    xfer(1'h1, 12'h080, {16'h0000, w}, q, e);
  endtask
endmodule // ofcr_apb_host
`default_nettype wire

//--- bench/ofcr_regs_tb_top.sv
// bench for the front-end control register bank
// assumes the apb host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module ofcr_regs_tb_top;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel, penable, pwrite, pready, pslverr, bad_word, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  summed_input_gain, radial_tracking_method;
  logic        dvd_monitor_level, cd_monitor_level, dvd_laser_enable, cd_laser_enable;
  logic        power_up_bit, phase_offset_source_sel, radial_polarity;
  logic        dropout_conceal_enable, focus_four_channel, rf_input_source_sel;
  logic        focus_offset_dac_enable, servo_offset_range_sel;
  logic [5:0]  phase_offset_value, summed_offset_value;
  logic [3:0]  radial_output_gain, central_output_gain, central_offset_a;
  logic [3:0]  central_offset_b, central_offset_c, central_offset_d;
  logic [7:0]  pwr_out, mode_out;
  logic [24:0] svo;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  assign pwr_out = {summed_input_gain, dvd_monitor_level, cd_monitor_level,
                    dvd_laser_enable, cd_laser_enable, power_up_bit};
  assign mode_out = {phase_offset_source_sel, radial_polarity, dropout_conceal_enable,
                     focus_four_channel, radial_tracking_method, rf_input_source_sel};
  assign svo = {radial_output_gain, central_output_gain, central_offset_a, central_offset_b,
                central_offset_c, central_offset_d, focus_offset_dac_enable};
  ofcr_regs dut (.*);
  ofcr_apb_host host (.*);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // one edge past the store edge, where the lagging outputs land
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, q, e);
    @(posedge pclk);
    #1;
  endtask
  task t_reset;
    chk("reset power", 32'h0000_0000, 32'(pwr_out));
    chk("reset mode", 32'h0000_0040, 32'(mode_out));
    chk("reset servo", 32'h0000_0001, 32'(svo));
  endtask
  task t_pwr;
    logic [7:0] v;
    for (int g = 0; g < 5; g++) begin
      v = {g[2:0], 5'h0a ^ {5{g[0]}}};
      wr(12'h000, {24'hff_ff0f, v});
      chk("reg0 outputs", {24'h00_0000, v}, 32'(pwr_out));
      host.xfer(1'h0, 12'h000, 32'h0000_0000, q, e);
      chk("reg0 readback", {24'h00_0000, v}, q);
    end
  endtask
  task t_mode;
    logic [2:0] rt [7];
    logic       p;
    rt = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
    for (int i = 0; i < 7; i++) begin
      p = i[0];
      wr(12'h004, {20'h0_0000, p, 2'h3, ~p, 2'h3, p, ~p, rt[i], p});
      chk("mode outputs", {24'h00_0000, p, ~p, p, ~p, rt[i], p}, 32'(mode_out));
      chk("reg0 kept", 32'h0000_0004, 32'(summed_input_gain));
    end
    host.xfer(1'h0, 12'h004, 32'h0000_0000, q, e);
    chk("reg1 readback", 32'h0000_111e, q);
  endtask
  task t_offs;
    wr(12'h004, 32'h0000_0100);
    wr(12'h010, 32'h0000_0abc);
    wr(12'h014, 32'h0000_0015);
    chk("left offset", 32'h0000_002a, 32'(phase_offset_value));
    wr(12'h004, 32'h0000_0101);
    wr(12'h010, 32'h0000_0f27);
    chk("shared offset", 32'h0000_09e7, 32'({phase_offset_value, summed_offset_value}));
    wr(12'h004, 32'h0000_0901);
    chk("summed offset", 32'h0000_0015, 32'(phase_offset_value));
  endtask
  task t_servo;
    wr(12'h018, 32'h0000_0a50);
    wr(12'h030, 32'h0000_00c3);
    wr(12'h034, 32'h0000_003c);
    wr(12'h008, 32'h0000_0400);
    chk("servo", 32'h014b_8678, 32'(svo));
    wr(12'h040, 32'h0000_0001);
    chk("offset range", 32'h0000_0001, 32'(servo_offset_range_sel));
  endtask
  task t_word;
    host.word(16'h0016);
    @(posedge pclk);
    #1;
    chk("word reg0", 32'h0000_0016, 32'(pwr_out));
    host.word(16'h1000);
    @(posedge pclk);
    #1;
    chk("word reg1", 32'h0000_0000, 32'(mode_out));
    chk("reg0 kept", 32'h0000_0016, 32'(pwr_out));
    host.word(16'h3fff);
    @(posedge pclk);
    #1;
    chk("bad selector flag", 32'h0000_0001, 32'(bad_word));
    chk("reg1 kept", 32'h0000_0000, 32'(mode_out));
    host.xfer(1'h0, 12'h040, 32'h0000_0000, q, e);
    chk("status read", 32'h0000_0003, q);
    chk("status no error", 32'h0000_0000, 32'(e));
    chk("pready level", 32'h0000_0001, 32'(pready));
    wr(12'h040, 32'h0000_0002);
    chk("flag cleared", 32'h0000_0000, 32'(bad_word));
    chk("range cleared", 32'h0000_0000, 32'(servo_offset_range_sel));
    host.xfer(1'h0, 12'h044, 32'h0000_0000, q, e);
    chk("unmapped error", 32'h0000_0001, 32'(e));
    chk("unmapped data", 32'h0000_0000, q);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    t_reset();
    t_pwr();
    t_mode();
    t_offs();
    t_servo();
    t_word();
    stop_test();
  end
endmodule // ofcr_regs_tb_top
`default_nettype wire
